// ===== hw/sasc_seq.sv
// Behaviour
// - Start-strobe conversion takes 27 converter clock periods in total.
// - Track/hold launched conversion completes within 34 converter clock periods.
// - Start-strobe mode times its own acquisition window of 7 periods.
// - Offset nulling plus acquisition lasts 33 periods before conversion steps.
// - Unsynchronised clock: acquisition ends 6 to 7 periods after start edge.
// - Synchronous falling clock edge: acquisition ends 6.5 periods after start.
// - Read or start strobe falling edge returns result-ready flag high.
// - Data bus driven while read is low, released when read rises.
// - Select low, rising start strobe begins a conversion.
// - Select low, track/hold falling opens acquisition, rising starts conversion.
// - Calibrate request drives busy low for 1399 clock periods.
// - Offset-null input low adds a 26 period nulling cycle to a start-strobe launch.
`timescale 1ns/100ps
`include "sasc_map.svh"

module sasc_seq
  import sasc_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   conv_clock_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   wr_n_i,
  input  wire logic                   rd_n_i,
  input  wire logic                   sh_n_i,
  input  wire logic                   cal_n_i,
  input  wire logic                   offset_null_n_i,
  input  wire logic [`SASC_RES_W-1:0] result_i,
  output logic                        eoc_o,
  output logic                        int_n_o,
  output logic [7:0]                  data_o,
  output logic                        data_oe_o
);

  // ==========================================================
  // Phase lengths
  localparam logic [`SASC_CNT_W-1:0] CONV_WR = `SASC_WR_TOTAL - `SASC_ACQ_CYC;

  function automatic logic [`SASC_CNT_W-1:0] phase_len(input sasc_state_t st, input logic sh);
    logic [`SASC_CNT_W-1:0] len;
    len = `SASC_ACQ_CYC;
    unique case (st)
      SASC_NULL: len = `SASC_NULL_CYC;
      SASC_CONV: len = sh ? `SASC_SH_TOTAL : CONV_WR;
      SASC_CAL:  len = `SASC_CAL_CYC;
      SASC_IDLE,
      SASC_ACQ:  len = `SASC_ACQ_CYC;
    endcase
    return len;
  endfunction

  // ==========================================================
  // Input edge detection
  sasc_state_t            state_q;
  sasc_state_t            state_d;
  logic [`SASC_CNT_W-1:0] cnt_q;
  logic                   clk_prev_q;
  logic                   wr_prev_q;
  logic                   rd_prev_q;
  logic                   sh_prev_q;
  logic                   sh_mode_q;
  logic                   az_q;
  logic                   tick;
  logic                   wr_rise;
  logic                   wr_fall;
  logic                   rd_fall;
  logic                   sh_rise;
  logic                   sh_fall;
  logic                   phase_done;
  logic                   conv_end;
  logic                   rd_act;
  logic [`SASC_RES_W-1:0] res_q;
  logic                   byte_lo_q;

  // Previous input levels
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clk_prev_q <= 1'b0;
      wr_prev_q  <= 1'b1;
      rd_prev_q  <= 1'b1;
      sh_prev_q  <= 1'b1;
    end
    else
    begin
      clk_prev_q <= conv_clock_i;
      wr_prev_q  <= wr_n_i;
      rd_prev_q  <= rd_n_i;
      sh_prev_q  <= sh_n_i;
    end
  end

  // Qualified strobe edges
  assign tick       = conv_clock_i & ~clk_prev_q;
  assign wr_rise    = ~cs_n_i & wr_n_i & ~wr_prev_q;
  assign wr_fall    = ~cs_n_i & ~wr_n_i & wr_prev_q;
  assign rd_fall    = ~cs_n_i & ~rd_n_i & rd_prev_q;
  assign sh_rise    = ~cs_n_i & sh_n_i & ~sh_prev_q;
  assign sh_fall    = ~cs_n_i & ~sh_n_i & sh_prev_q;
  assign rd_act     = ~cs_n_i & ~rd_n_i;
  assign phase_done = tick && (cnt_q == phase_len(state_q, sh_mode_q) - 11'h001);
  assign conv_end   = (state_q == SASC_CONV) && phase_done && cal_n_i;

  // ==========================================================
  // Sequencer
  // Next phase; calibrate low overrides everything
  always_comb
  begin
    state_d = state_q;
    if (!cal_n_i)
      state_d = SASC_CAL;
    else
    begin
      unique case (state_q)
        SASC_IDLE:
          if (wr_rise)
            state_d = offset_null_n_i ? SASC_ACQ : SASC_NULL;
          else if (sh_fall)
            state_d = SASC_ACQ;
        SASC_NULL:
          if (phase_done)
            state_d = SASC_ACQ;
        SASC_ACQ:
          if (sh_mode_q ? sh_rise : phase_done)
            state_d = SASC_CONV;
        SASC_CONV:
          if (phase_done)
            state_d = SASC_IDLE;
        SASC_CAL:
          if (phase_done)
            state_d = SASC_IDLE;
        default:
          state_d = SASC_IDLE;
      endcase
    end
  end

  // Phase state and per-phase period counter
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= SASC_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q || !cal_n_i)
        cnt_q <= '0;
      else if (tick && state_q != SASC_IDLE)
        cnt_q <= cnt_q + 11'h001;
    end
  end

  // Launch mode and offset-null choice, held for the whole sequence
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sh_mode_q <= 1'b0;
      az_q      <= 1'b0;
    end
    else if (state_q == SASC_IDLE && cal_n_i)
    begin
      if (wr_rise)
      begin
        sh_mode_q <= 1'b0;
        az_q      <= ~offset_null_n_i;
      end
      else if (sh_fall)
      begin
        sh_mode_q <= 1'b1;
        az_q      <= 1'b0;
      end
    end
  end

  // Busy low while converting or calibrating
  assign eoc_o = !(state_q == SASC_CONV || state_q == SASC_CAL);

  // ==========================================================
  // Result and flag
  // Result ready flag; completion wins over a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      int_n_o <= 1'b1;
    else if (conv_end)
      int_n_o <= 1'b0;
    else if (rd_fall || wr_fall || !cal_n_i)
      int_n_o <= 1'b1;
  end

  // Result latch and byte pointer, high byte first
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      res_q     <= '0;
      byte_lo_q <= 1'b0;
    end
    else if (conv_end)
    begin
      res_q     <= result_i;
      byte_lo_q <= 1'b0;
    end
    else if (data_oe_o && !rd_act)
      byte_lo_q <= ~byte_lo_q;
  end

  // Bus drive while read is active
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_oe_o <= rd_act;
      if (rd_act && !data_oe_o)
        data_o <= byte_lo_q ? res_q[7:0] : {{4{res_q[`SASC_SIGN_BIT]}}, res_q[11:8]};
    end
  end

  // ==========================================================
  // Checks
  logic [`SASC_CNT_W-1:0] seq_q;

  // Periods elapsed since launch, or since the track/hold rise in track/hold mode
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      seq_q <= '0;
    else if (state_q == SASC_IDLE || (state_q == SASC_ACQ && sh_mode_q))
      seq_q <= '0;
    else if (tick)
      seq_q <= seq_q + 11'h001;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  wr_total_a: assert property (conv_end && !sh_mode_q && !az_q |-> seq_q + 11'h001 == `SASC_WR_TOTAL)
    else $error("start strobe conversion length wrong");
  sh_total_a: assert property (conv_end && sh_mode_q |-> seq_q + 11'h001 == `SASC_SH_TOTAL)
    else $error("track hold conversion length wrong");
  acq_window_a: assert property (state_q == SASC_ACQ && state_d == SASC_CONV && !sh_mode_q && !az_q
                                 |-> seq_q + 11'h001 == `SASC_ACQ_CYC)
    else $error("acquisition window length wrong");
  null_acq_a: assert property (state_q == SASC_ACQ && state_d == SASC_CONV && az_q
                               |-> seq_q + 11'h001 == `SASC_ZA_CYC)
    else $error("null plus acquisition length wrong");
  null_total_a: assert property (conv_end && az_q
                                 |-> seq_q + 11'h001 == `SASC_WR_TOTAL + `SASC_NULL_CYC)
    else $error("nulling did not add its periods");
  cal_busy_a: assert property (state_q == SASC_CAL && state_d == SASC_IDLE
                               |-> !eoc_o && cnt_q + 11'h001 == `SASC_CAL_CYC)
    else $error("calibration length wrong");
  int_clear_a: assert property ((rd_fall || wr_fall) && !conv_end |=> int_n_o)
    else $error("result flag not cleared by strobe");
  bus_release_a: assert property (data_oe_o && !rd_act |=> !data_oe_o)
    else $error("bus not released after read");
  sh_start_a: assert property (state_q == SASC_ACQ && sh_mode_q && sh_rise && cal_n_i
                               |=> state_q == SASC_CONV ##1 !eoc_o)
    else $error("track hold rise did not start conversion");
  wr_launch_a: assert property (state_q == SASC_IDLE && wr_rise && cal_n_i |=> state_q != SASC_IDLE)
    else $error("start strobe did not launch");

  wr_conv_c: cover property (conv_end && !sh_mode_q && !az_q);
  sh_conv_c: cover property (conv_end && sh_mode_q);
  az_conv_c: cover property (conv_end && az_q);
  cal_done_c: cover property (state_q == SASC_CAL && state_d == SASC_IDLE);
  two_reads_c: cover property (rd_fall ##[1:200] rd_fall);

endmodule

// ===== hw/sasc_map.svh
`ifndef SASC_MAP_SVH
`define SASC_MAP_SVH
// ==========================================================
// Phase lengths in converter clock periods
`define SASC_CNT_W     11
`define SASC_NULL_CYC  11'h01A
`define SASC_ACQ_CYC   11'h007
`define SASC_WR_TOTAL  11'h01B
`define SASC_SH_TOTAL  11'h022
`define SASC_ZA_CYC    11'h021
`define SASC_CAL_CYC   11'h577
// ==========================================================
// Output byte layout
`define SASC_SIGN_BIT  12
`define SASC_RES_W     13
`endif

// ===== hw/sasc_pkg.sv
package sasc_pkg;
  // Sequencer phases, Gray coded along idle-null-acquire-convert
  typedef enum logic [2:0] {
    SASC_IDLE = 3'h0,
    SASC_NULL = 3'h1,
    SASC_ACQ  = 3'h3,
    SASC_CONV = 3'h2,
    SASC_CAL  = 3'h6
  } sasc_state_t;
endpackage

// ===== test/sasc_host.sv
`timescale 1ns/100ps
// ==========================================================
// Host bus model, strobes change just after the rising edge
module sasc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       oe_i,
  output logic            cs_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            sh_n_o,
  output logic            cal_n_o,
  output logic            null_n_o
);
  // Released bus floats to the inverse of its last byte
  logic [7:0] bus;
  assign bus = oe_i ? data_i : ~data_i;

  // Idle levels with calibrate released before any launch
  initial
  begin
    cs_n_o   = 1'b0;
    wr_n_o   = 1'b1;
    rd_n_o   = 1'b1;
    sh_n_o   = 1'b1;
    cal_n_o  = 1'b1;
    null_n_o = 1'b1;
  end

  // Start strobe, launch at its rising edge when selected
  task automatic wr_pulse(input logic nul, input logic sel);
    @(posedge clk_i);
    cs_n_o   <= ~sel;
    null_n_o <= ~nul;
    wr_n_o   <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
  endtask

  // Track/hold low for n cycles, rise starts conversion
  task automatic sh_hold(input int n);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    sh_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    sh_n_o <= 1'b1;
  endtask

  // Calibrate pulse of four cycles
  task automatic cal_pulse();
    @(posedge clk_i) cal_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cal_n_o <= 1'b1;
  endtask

  // One byte read, bus sampled while the strobe is still low
  task automatic read(output logic [7:0] b, output logic oe);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    b = bus;
    oe = oe_i;
    rd_n_o <= 1'b1;
  endtask
endmodule

// ===== test/tb_sasc_seq.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end

module tb_sasc_seq;
  localparam logic [12:0] RES = 13'h1_a5c;
  logic       clk;
  logic       rstn;
  logic       cs_n, wr_n, rd_n, sh_n, cal_n, null_n;
  logic       eoc, int_n, oe, oe_s;
  logic [7:0] data, b;
  logic [2:0] div = 3'h0;
  int         ticks = 0;
  int         t0, n_fail = 0, n_compared = 0;

  // ==========================================================
  // Clock, reset and a converter clock of eight system cycles
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) div <= div + 3'h1;
  always @(posedge clk) if (div == 3'h3) ticks <= ticks + 1;

  sasc_host host (.clk_i(clk), .data_i(data), .oe_i(oe), .cs_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .sh_n_o(sh_n), .cal_n_o(cal_n), .null_n_o(null_n));
  sasc_seq dut (.sys_clk_i(clk), .rstn_i(rstn), .conv_clock_i(div[2]), .cs_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .sh_n_i(sh_n), .cal_n_i(cal_n), .offset_null_n_i(null_n),
    .result_i(RES), .eoc_o(eoc), .int_n_o(int_n), .data_o(data), .data_oe_o(oe));

  // ==========================================================
  // Shared helpers
  task automatic wait_lvl(input logic is_int, input logic lvl);
    for (int i = 0; i < 20000 && (is_int ? int_n : eoc) !== lvl; i++)
    begin
      @(posedge clk);
      #1;
    end
    if ((is_int ? int_n : eoc) !== lvl)
      n_fail++;
  endtask
  // Park just after a converter clock rise so launches avoid it
  task automatic align();
    do
    begin
      @(posedge clk);
      #1;
    end while (div !== 3'h4);
  endtask

  // ==========================================================
  // Scenarios
  task automatic conv_wr(input logic nul);
    align();
    host.wr_pulse(nul, 1'b1);
    t0 = ticks;
    `CHK(int_n, 1'b1)
    wait_lvl(0, 0);
    `CHK(ticks - t0, nul ? 33 : 7)
    wait_lvl(1, 0);
    `CHK(ticks - t0, nul ? 53 : 27)
    `CHK(eoc, 1'b1)
  endtask
  task automatic conv_sh();
    align();
    host.sh_hold(20);
    t0 = ticks;
    wait_lvl(0, 0);
    `CHK(ticks - t0, 0)
    wait_lvl(1, 0);
    `CHK(ticks - t0, 34)
  endtask
  task automatic read_pair();
    host.read(b, oe_s);
    `CHK({oe_s, b}, {1'b1, {4{RES[12]}}, RES[11:8]})
    `CHK(int_n, 1'b1)
    repeat (3) @(posedge clk);
    #1 `CHK(oe, 1'b0)
    host.read(b, oe_s);
    `CHK({oe_s, b}, {1'b1, RES[7:0]})
  endtask
  task automatic cs_ignored();
    host.wr_pulse(1'b0, 1'b0);
    repeat (80) @(posedge clk);
    `CHK(eoc, 1'b1)
  endtask
  task automatic calib();
    align();
    host.cal_pulse();
    t0 = ticks;
    `CHK(eoc, 1'b0)
    wait_lvl(0, 1);
    `CHK(ticks - t0, 1399)
    `CHK(int_n, 1'b1)
  endtask

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    calib();
    conv_wr(1'b0);
    conv_wr(1'b1);
    calib();
    cs_ignored();
    conv_sh();
    read_pair();
    complete_run();
  end

  // Watchdog well beyond two calibrations plus conversions
  initial
  begin
    repeat (50000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
